// >>> shared/bmvp_pkg.sv
// shared constants for the boot map and vector priority block
package bmvp_pkg;
   localparam int          BMVP_NVEC       = 22;
   localparam int          BMVP_VW         = 5;
   localparam logic [20:0] BMVP_INT_BOOT   = 21'h020000;
   localparam logic [20:0] BMVP_INT_WDOG   = 21'h020002;
   localparam logic [20:0] BMVP_EXT16_BOOT = 21'h000000;
   localparam logic [20:0] BMVP_EXT16_WDOG = 21'h000002;
   localparam logic [20:0] BMVP_EXT20_BOOT = 21'h020000;
   localparam logic [20:0] BMVP_EXT20_WDOG = 21'h020002;
   localparam logic [20:0] BMVP_FLASH_LO   = 21'h000000;
   localparam logic [20:0] BMVP_FLASH_HI   = 21'h00ffff;
   localparam logic [20:0] BMVP_REMAP_LO   = 21'h010000;
   localparam logic [20:0] BMVP_REMAP_HI   = 21'h01ffff;
   localparam logic [20:0] BMVP_BOOT_LO    = 21'h020000;
   localparam logic [20:0] BMVP_BOOT_HI    = 21'h020fff;
   localparam logic [20:0] BMVP_PRAM_LO    = 21'h02f800;
   localparam logic [20:0] BMVP_PRAM_HI    = 21'h02ffff;
   localparam logic [20:0] BMVP_LOW_TOP    = 21'h00ffff;
   localparam logic [20:0] BMVP_HIGH_EXT   = 21'h100000;
   localparam logic [1:0]  BMVP_LVL3       = 2'h3;
   localparam logic [1:0]  BMVP_LVL2       = 2'h2;
   localparam logic [1:0]  BMVP_LVL1       = 2'h1;
   localparam logic [1:0]  BMVP_LVL0       = 2'h0;
   // vectors that exist; 0,1,8,12,13,19 are reserved
   localparam logic [21:0] BMVP_LIVE_MASK  = 22'h37cefc;
   // vectors whose level is programmable; rest are fixed
   localparam logic [21:0] BMVP_PROG_MASK  = 22'h360ec0;
   localparam logic [4:0]  BMVP_VEC_SW2    = 5'h0e;
   localparam logic [4:0]  BMVP_VEC_SW1    = 5'h0f;
   localparam logic [4:0]  BMVP_VEC_SW0    = 5'h10;
   typedef enum logic [1:0] {BMVP_SRC_INT, BMVP_SRC_FLASH, BMVP_SRC_BOOT, BMVP_SRC_EXT} bmvp_src_t;
   typedef enum logic [1:0] {BMVP_MODE_INT, BMVP_MODE_EXT16, BMVP_MODE_EXT20} bmvp_mode_t;
endpackage : bmvp_pkg

// >>> design/bmvp_arbiter.sv
// priority arbiter over the vector table
`timescale 1ns/100ps
`default_nettype none
module bmvp_arbiter
   import bmvp_pkg::*;
(
   // requests and levels
   input  wire logic [21:0]   req,
   input  wire logic [43:0]   level,
   input  wire logic [1:0]    mask_level,
   // result
   output logic               found,
   output logic [4:0]         vec
);
   always_comb begin
      logic [1:0] best;
      best  = BMVP_LVL0;
      found = 1'b0;
      vec   = 5'h00;
      // scan downward so the lowest number wins ties
      for (int i = BMVP_NVEC - 1; i >= 0; i--) begin
         if (req[i] && BMVP_LIVE_MASK[i] && level[2*i +: 2] >= mask_level) begin
            if (!found || level[2*i +: 2] >= best) begin
               found = 1'b1;
               best  = level[2*i +: 2];
               vec   = 5'(i);
            end
         end
      end
   end
endmodule : bmvp_arbiter
`default_nettype wire

// >>> design/bmvp_top.sv
// boot map selection, program space decode and vector arbitration
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - width select level caught at reset changes the external reset vector.
// - internal boot: reset at 0x020000, watchdog reset at 0x020002.
// - external 16-bit boot: reset at 0x000000, watchdog at 0x000002.
// - external 16-bit boot remaps internal flash to 0x010000-0x01ffff.
// - external 20-bit boot fetches vectors externally at 0x020000/0x020002.
// - external boot never fetches reset from boot flash.
// - secured flash forbids external boot; internal boot is used.
// - external memory at 0x100000 and up needs upper pins reconfigured.
// - external regions above 0x00ffff need higher pins reconfigured; in 20-bit mode only from 0x100000 up.
// - higher priority levels always serviced before lower levels.
// - equal level: lowest vector number wins.
// - vector address is base plus twice the vector number.
// - vector slots 0 and 1 reserved as reset overlays.
// - vectors 2 to 5 fixed at level 3.
// - debug vectors 6,7,9,10,11 programmable 1 to 3; vector 8 reserved.
// - soft interrupts 14-16 fixed 2,1,0; request lines 17,18 programmable 0-2.
// - low voltage vector 20, clock synth vector 21 programmable 0-2; 19 reserved.
// - at reset map bit takes boot pin, secured bit takes flash state.
// - map bit writable after reset, no effect when secured bit was 0.
module bmvp_top
   import bmvp_pkg::*;
(
   // clock and reset
   input  wire logic          clock,
   input  wire logic          rst_n,
   // straps
   input  wire logic          external_boot_pin,
   input  wire logic          ext_addr_width_select,
   input  wire logic          flash_secured,
   // mode register write
   input  wire logic          map_select_wr,
   input  wire logic          map_select_wdata,
   input  wire logic          upper_pins_enable,
   // program fetch decode
   input  wire logic [20:0]   fetch_addr,
   output logic [1:0]         fetch_src,
   output logic [20:0]        fetch_local,
   output logic               fetch_fault,
   // reset vectors
   output logic [20:0]        reset_vector,
   output logic [20:0]        wdog_vector,
   output logic               map_select_bit,
   output logic               secured_state_bit,
   output logic               ext_addr_20bit,
   // interrupts
   input  wire logic [20:0]   vector_base,
   input  wire logic [21:0]   irq_req,
   input  wire logic [1:0]    mask_level,
   input  wire logic [1:0]    dbg_step_level,
   input  wire logic [1:0]    dbg_brk_level,
   input  wire logic [1:0]    dbg_trace_level,
   input  wire logic [1:0]    dbg_tx_level,
   input  wire logic [1:0]    dbg_rx_level,
   input  wire logic [1:0]    ext_request_a_level,
   input  wire logic [1:0]    ext_request_b_level,
   input  wire logic [1:0]    low_voltage_detect_level,
   input  wire logic [1:0]    clock_synth_level,
   output logic               irq_pending,
   output logic [4:0]         irq_vector,
   output logic [20:0]        irq_addr
);
   // pins pass two flops first
   logic [1:0] boot_sync_reg;
   logic [1:0] width_sync_reg;
   logic [1:0] sec_sync_reg;
   logic       strap_done_reg;
   logic       map_reg;
   logic       secured_reg;
   logic       width_reg;
   bmvp_mode_t mode;

   // straps are caught at the third edge, debug_unit both sync stages hold the pin
   localparam logic [1:0] STRAP_LAST    = 2'h2;
   // vector numbers of the fixed core exceptions and of programmable sources
   localparam int         VEC_CORE_LO   = 2;
   localparam int         VEC_CORE_HI   = 5;
   localparam int         VEC_DBG_STEP  = 6;
   localparam int         VEC_DBG_BRK   = 7;
   localparam int         VEC_DBG_TRACE = 9;
   localparam int         VEC_DBG_TX    = 10;
   localparam int         VEC_DBG_RX    = 11;
   localparam int         VEC_EXT_A     = 17;
   localparam int         VEC_EXT_B     = 18;
   localparam int         VEC_LOW_VOLT  = 20;
   localparam int         VEC_CLK_SYNTH = 21;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         boot_sync_reg  <= 2'h0;
         width_sync_reg <= 2'h0;
         sec_sync_reg   <= 2'h0;
      end else begin
         boot_sync_reg  <= {boot_sync_reg[0], external_boot_pin};
         width_sync_reg <= {width_sync_reg[0], ext_addr_width_select};
         sec_sync_reg   <= {sec_sync_reg[0], flash_secured};
      end
   end

   // straps are caught debug_unit, after the synchronisers have filled
   logic [1:0] strap_cnt_reg;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         strap_cnt_reg  <= 2'h0;
         strap_done_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         strap_cnt_reg  <= strap_cnt_reg + 2'h1;
         strap_done_reg <= (strap_cnt_reg == STRAP_LAST);
      end
   end

   // secured_reg holds 1 when flash is not secured, as the mode bit does
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         secured_reg <= 1'b0;
         width_reg   <= 1'b0;
      end else if (!strap_done_reg) begin
         secured_reg <= ~sec_sync_reg[1];
         width_reg   <= width_sync_reg[1];
      end
   end

   // the map bit alone stays writable after the straps are caught;
   // a write that lands while the straps are still settling is dropped
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         map_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         map_reg <= boot_sync_reg[1] & ~sec_sync_reg[1];
      end else if (map_select_wr && secured_reg) begin
         map_reg <= map_select_wdata;
      end
   end

   always_comb begin
      if (!map_reg)
         mode = BMVP_MODE_INT;
      else if (width_reg)
         mode = BMVP_MODE_EXT20;
      else
         mode = BMVP_MODE_EXT16;
   end

   assign map_select_bit    = map_reg;
   assign secured_state_bit = secured_reg;
   assign ext_addr_20bit    = width_reg & map_reg;

   // reset and watchdog vectors
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reset_vector <= BMVP_INT_BOOT;
         wdog_vector  <= BMVP_INT_WDOG;
      end else begin
         unique case (mode)
            BMVP_MODE_INT: begin
               reset_vector <= BMVP_INT_BOOT;
               wdog_vector  <= BMVP_INT_WDOG;
            end
            BMVP_MODE_EXT16: begin
               reset_vector <= BMVP_EXT16_BOOT;
               wdog_vector  <= BMVP_EXT16_WDOG;
            end
            default: begin
               // shadows boot flash with external memory
               reset_vector <= BMVP_EXT20_BOOT;
               wdog_vector  <= BMVP_EXT20_WDOG;
            end
         endcase
      end
   end

   function automatic logic in_range(input logic [20:0] a, input logic [20:0] lo,
                                     input logic [20:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   // offset of a fetch inside the relocated flash window
   function automatic logic [20:0] remap_offset(input logic [20:0] a);
      remap_offset = a - BMVP_REMAP_LO;
   endfunction : remap_offset

   // program space decode, registered
   bmvp_src_t   src;
   logic [20:0] local_a;
   logic        fault;
   always_comb begin
      src     = BMVP_SRC_EXT;
      local_a = fetch_addr;
      unique case (mode)
         // internal boot: flash low, boot flash and program ram above it
         BMVP_MODE_INT: begin
            if (in_range(fetch_addr, BMVP_FLASH_LO, BMVP_FLASH_HI))
               src = BMVP_SRC_FLASH;
            else if (in_range(fetch_addr, BMVP_BOOT_LO, BMVP_BOOT_HI))
               src = BMVP_SRC_BOOT;
            else if (in_range(fetch_addr, BMVP_PRAM_LO, BMVP_PRAM_HI))
               src = BMVP_SRC_INT;
         end
         // external 16-bit: the low 64K goes out, flash moves up one window
         BMVP_MODE_EXT16: begin
            if (in_range(fetch_addr, BMVP_REMAP_LO, BMVP_REMAP_HI)) begin
               src     = BMVP_SRC_FLASH;
               local_a = remap_offset(fetch_addr);
            end else if (in_range(fetch_addr, BMVP_BOOT_LO, BMVP_BOOT_HI))
               src = BMVP_SRC_BOOT;
            else if (in_range(fetch_addr, BMVP_PRAM_LO, BMVP_PRAM_HI))
               src = BMVP_SRC_INT;
         end
         // external 20-bit: boot flash is shadowed by external memory
         default: begin
            if (in_range(fetch_addr, BMVP_REMAP_LO, BMVP_REMAP_HI)) begin
               src     = BMVP_SRC_FLASH;
               local_a = remap_offset(fetch_addr);
            end else if (in_range(fetch_addr, BMVP_PRAM_LO, BMVP_PRAM_HI))
               src = BMVP_SRC_INT;
         end
      endcase
   end

   // external space above the low 64K waits for the upper pins, except in the
   // 20-bit mode, where only space from 0x100000 up still waits for them
   always_comb begin
      fault = 1'b0;
      if (src == BMVP_SRC_EXT && fetch_addr > BMVP_LOW_TOP && mode != BMVP_MODE_EXT20
          && !upper_pins_enable)
         fault = 1'b1;
      if (fetch_addr >= BMVP_HIGH_EXT && !upper_pins_enable)
         fault = 1'b1;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fetch_src   <= 2'h0;
         fetch_local <= 21'h000000;
         fetch_fault <= 1'b0;
      end else begin
         fetch_src   <= src;
         fetch_local <= local_a;
         fetch_fault <= fault;
      end
   end

   // debug sources never sit below level 1; a 0 written there reads as 1
   function automatic logic [1:0] clamp_dbg(input logic [1:0] l);
      clamp_dbg = (l == BMVP_LVL0) ? BMVP_LVL1 : l;
   endfunction : clamp_dbg

   // peripheral sources never reach level 3, so core exceptions always win
   function automatic logic [1:0] clamp_per(input logic [1:0] l);
      clamp_per = (l == BMVP_LVL3) ? BMVP_LVL2 : l;
   endfunction : clamp_per

   // table entries are two words apart
   function automatic logic [20:0] entry_offset(input logic [4:0] v);
      entry_offset = {15'h0000, v, 1'b0};
   endfunction : entry_offset

   // level table
   logic [2*BMVP_NVEC-1:0] level;
   always_comb begin
      level = '0;
      for (int i = VEC_CORE_LO; i <= VEC_CORE_HI; i++) begin
         level[2*i +: 2] = BMVP_LVL3;
      end
      level[2*VEC_DBG_STEP +: 2]  = clamp_dbg(dbg_step_level);
      level[2*VEC_DBG_BRK +: 2]   = clamp_dbg(dbg_brk_level);
      level[2*VEC_DBG_TRACE +: 2] = clamp_dbg(dbg_trace_level);
      level[2*VEC_DBG_TX +: 2]    = clamp_dbg(dbg_tx_level);
      level[2*VEC_DBG_RX +: 2]    = clamp_dbg(dbg_rx_level);
      level[2*BMVP_VEC_SW2 +: 2]  = BMVP_LVL2;
      level[2*BMVP_VEC_SW1 +: 2]  = BMVP_LVL1;
      level[2*BMVP_VEC_SW0 +: 2]  = BMVP_LVL0;
      level[2*VEC_EXT_A +: 2]     = clamp_per(ext_request_a_level);
      level[2*VEC_EXT_B +: 2]     = clamp_per(ext_request_b_level);
      level[2*VEC_LOW_VOLT +: 2]  = clamp_per(low_voltage_detect_level);
      level[2*VEC_CLK_SYNTH +: 2] = clamp_per(clock_synth_level);
   end

   logic       found;
   logic [4:0] win;
   // reserved slots are masked here and again in the arbiter, so a stray
   // request on one of them can never be granted
   bmvp_arbiter u_arb (
      .req        (irq_req & BMVP_LIVE_MASK),
      .level      (level),
      .mask_level (mask_level),
      .found      (found),
      .vec        (win)
   );

   // same-cycle delivery of the winner to the core; a registered vector would
   // answer a cycle late and could hand over a request already dropped
   assign irq_pending = found;
   assign irq_vector  = win;
   assign irq_addr    = vector_base + entry_offset(win);
endmodule : bmvp_top
`default_nettype wire

// >>> bench/bmvp_checker.sv
// port-level assertions for the boot map and vector priority block
`timescale 1ns/100ps
`default_nettype none
module bmvp_checker
   import bmvp_pkg::*;
(
   // clock and reset
   input wire logic        clock,
   input wire logic        rst_n,
   // fetch decode and boot mode
   input wire logic        upper_pins_enable,
   input wire logic [20:0] fetch_addr,
   input wire logic [1:0]  fetch_src,
   input wire logic        fetch_fault,
   input wire logic [20:0] reset_vector,
   input wire logic [20:0] wdog_vector,
   input wire logic        map_select_bit,
   input wire logic        secured_state_bit,
   input wire logic        ext_addr_20bit,
   // interrupts
   input wire logic [20:0] vector_base,
   input wire logic [21:0] irq_req,
   input wire logic        irq_pending,
   input wire logic [4:0]  irq_vector,
   input wire logic [20:0] irq_addr
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   sequence s_far_fetch;
      fetch_addr >= BMVP_HIGH_EXT && !upper_pins_enable;
   endsequence
   sequence s_remap_fetch;
      map_select_bit && !ext_addr_20bit && fetch_addr[20:16] == 5'h01;
   endsequence
   sequence s_low_ext_fetch;
      !map_select_bit && fetch_addr[20:16] == 5'h01 && !upper_pins_enable;
   endsequence
   sequence s_ext20_boot_fetch;
      ext_addr_20bit && fetch_addr >= BMVP_BOOT_LO && fetch_addr <= BMVP_BOOT_HI;
   endsequence
   property p_far_fault;
      s_far_fetch |=> fetch_fault;
   endproperty
   property p_remap;
      s_remap_fetch |=> fetch_src == BMVP_SRC_FLASH && !fetch_fault;
   endproperty
   property p_ext20_boot;
      s_ext20_boot_fetch |=> fetch_src == BMVP_SRC_EXT && !fetch_fault;
   endproperty
   property p_low_fault;
      s_low_ext_fetch |=> fetch_src == BMVP_SRC_EXT && fetch_fault;
   endproperty
   property p_int_vec;
      !map_select_bit |=> reset_vector == BMVP_INT_BOOT;
   endproperty
   property p_ext16_vec;
      map_select_bit && !ext_addr_20bit |=> reset_vector == BMVP_EXT16_BOOT;
   endproperty
   property p_secure_lock;
      !secured_state_bit |-> !map_select_bit;
   endproperty
   property p_vec_pair;
      wdog_vector == reset_vector + 21'h000002;
   endproperty
   property p_addr;
      irq_pending |-> irq_addr == vector_base + {15'h0000, irq_vector, 1'b0};
   endproperty
   property p_live;
      irq_pending |-> BMVP_LIVE_MASK[irq_vector] && irq_req[irq_vector];
   endproperty
   property p_top3;
      irq_req[2] |-> irq_pending && irq_vector == 5'h02;
   endproperty
   property p_idle;
      (irq_req & BMVP_LIVE_MASK) == 22'h000000 |-> !irq_pending;
   endproperty
   a_far_fault: assert property (p_far_fault) else $error("far fetch not faulted");
   a_remap: assert property (p_remap) else $error("flash not remapped");
   a_ext20_boot: assert property (p_ext20_boot) else $error("boot window not external");
   a_secure_lock: assert property (p_secure_lock) else $error("map set while secured");
   a_vec_pair: assert property (p_vec_pair) else $error("reset vector pair broken");
   a_addr: assert property (p_addr) else $error("vector address wrong");
   a_live: assert property (p_live) else $error("dead vector granted");
   a_top3: assert property (p_top3) else $error("core exception lost");
   a_idle: assert property (p_idle) else $error("pending with no request");
   a_low_fault: assert property (p_low_fault) else $error("low external fetch not faulted");
   a_int_vec: assert property (p_int_vec) else $error("internal reset vector wrong");
   a_ext16_vec: assert property (p_ext16_vec) else $error("16-bit reset vector wrong");
endmodule : bmvp_checker
// every port watched by the checker is a port of the block
bind bmvp_top bmvp_checker i_bmvp_checker (
   .clock             (clock),
   .rst_n             (rst_n),
   .upper_pins_enable (upper_pins_enable),
   .fetch_addr        (fetch_addr),
   .fetch_src         (fetch_src),
   .fetch_fault       (fetch_fault),
   .reset_vector      (reset_vector),
   .wdog_vector       (wdog_vector),
   .map_select_bit    (map_select_bit),
   .secured_state_bit (secured_state_bit),
   .ext_addr_20bit    (ext_addr_20bit),
   .vector_base       (vector_base),
   .irq_req           (irq_req),
   .irq_pending       (irq_pending),
   .irq_vector        (irq_vector),
   .irq_addr          (irq_addr)
);
`default_nettype wire

// >>> bench/bmvp_core_model.sv
// processor core model that launches program fetch addresses
`timescale 1ns/100ps
`default_nettype none
module bmvp_core_model (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // address wanted by the bench, address seen by the block
   input  wire logic [20:0] want_addr,
   output logic [20:0]      fetch_addr
);
   // non-blocking launch, so the block never races the core at the edge
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fetch_addr <= 21'h000000;
      end else begin
         fetch_addr <= want_addr;
      end
   end
endmodule : bmvp_core_model
`default_nettype wire

// >>> bench/bmvp_top_test.sv
// self-checking bench for the boot map and vector priority block
`timescale 1ns/100ps
`default_nettype none
module bmvp_top_test;
   import bmvp_pkg::*;
   localparam logic [21:0] IRQ_RQ [10] = '{22'h024000, 22'h020040, 22'h020080, 22'h083103,
      22'h200000, 22'h200000, 22'h000088, 22'h050000, 22'h100400, 22'h000084};
   localparam logic [1:0] IRQ_MK [10] = '{2'h1, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0, 2'h2,
      2'h3};
   localparam logic [4:0] IRQ_VEC [10] = '{5'h0e, 5'h11, 5'h07, 5'h00, 5'h00, 5'h15, 5'h03,
      5'h12, 5'h14, 5'h02};
   logic clock = 1'b0, rst_n = 1'b0, external_boot_pin = 1'b0, ext_addr_width_select = 1'b0;
   logic flash_secured = 1'b0, map_select_wr = 1'b0, map_select_wdata = 1'b0;
   logic upper_pins_enable = 1'b0, fetch_fault, map_select_bit, secured_state_bit;
   logic ext_addr_20bit, irq_pending;
   logic [20:0] want_addr = 21'h000000, fetch_addr, fetch_local, reset_vector, wdog_vector;
   logic [20:0] vector_base = 21'h001000, irq_addr;
   logic [21:0] irq_req = 22'h000000;
   logic [1:0]  fetch_src, mask_level = 2'h0, dbg_step_level = 2'h1, dbg_brk_level = 2'h3;
   logic [1:0]  dbg_trace_level = 2'h2, dbg_tx_level = 2'h1, dbg_rx_level = 2'h2;
   logic [1:0]  ext_request_a_level = 2'h2, ext_request_b_level = 2'h1;
   logic [1:0]  low_voltage_detect_level = 2'h2, clock_synth_level = 2'h0;
   logic [4:0]  irq_vector;
   int          bad_count = 0;
   int          n_compared = 0;
   bmvp_top i_bmvp_top (
      .clock                    (clock),
      .rst_n                    (rst_n),
      .external_boot_pin        (external_boot_pin),
      .ext_addr_width_select    (ext_addr_width_select),
      .flash_secured            (flash_secured),
      .map_select_wr            (map_select_wr),
      .map_select_wdata         (map_select_wdata),
      .upper_pins_enable        (upper_pins_enable),
      .fetch_addr               (fetch_addr),
      .fetch_src                (fetch_src),
      .fetch_local              (fetch_local),
      .fetch_fault              (fetch_fault),
      .reset_vector             (reset_vector),
      .wdog_vector              (wdog_vector),
      .map_select_bit           (map_select_bit),
      .secured_state_bit        (secured_state_bit),
      .ext_addr_20bit           (ext_addr_20bit),
      .vector_base              (vector_base),
      .irq_req                  (irq_req),
      .mask_level               (mask_level),
      .dbg_step_level           (dbg_step_level),
      .dbg_brk_level            (dbg_brk_level),
      .dbg_trace_level          (dbg_trace_level),
      .dbg_tx_level             (dbg_tx_level),
      .dbg_rx_level             (dbg_rx_level),
      .ext_request_a_level      (ext_request_a_level),
      .ext_request_b_level      (ext_request_b_level),
      .low_voltage_detect_level (low_voltage_detect_level),
      .clock_synth_level        (clock_synth_level),
      .irq_pending              (irq_pending),
      .irq_vector               (irq_vector),
      .irq_addr                 (irq_addr)
   );
   bmvp_core_model i_bmvp_core_model (
      .clock      (clock),
      .rst_n      (rst_n),
      .want_addr  (want_addr),
      .fetch_addr (fetch_addr)
   );
   always #50 clock = ~clock;
   task chk(string what, logic [20:0] exp, logic [20:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task close_out;
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out
   // straps only settle the mode through a full reset, never on the fly
   task t_boot(logic pin, logic wid, logic sec, logic [20:0] rv, logic mapx);
      rst_n = 1'b0;
      external_boot_pin = pin;
      ext_addr_width_select = wid;
      flash_secured = sec;
      repeat (4) @(posedge clock);
      #1 rst_n = 1'b1;
      repeat (6) @(posedge clock);
      #1;
      chk("map bit", {20'h0, mapx}, {20'h0, map_select_bit});
      chk("secured bit", {20'h0, !sec}, {20'h0, secured_state_bit});
      chk("wide bus", {20'h0, wid & mapx}, {20'h0, ext_addr_20bit});
      chk("reset vector", rv, reset_vector);
      chk("wdog vector", rv + 21'h000002, wdog_vector);
      $display("boot case done");
   endtask : t_boot
   task t_fetch(logic [20:0] a, logic pins, logic [1:0] src, logic flt);
      want_addr = a;
      upper_pins_enable = pins;
      repeat (2) @(posedge clock);
      #1;
      chk("fetch src", {19'h0, src}, {19'h0, fetch_src});
      chk("fetch fault", {20'h0, flt}, {20'h0, fetch_fault});
      $display("fetch case done");
   endtask : t_fetch
   task t_map(logic exp);
      map_select_wr = 1'b1;
      map_select_wdata = 1'b1;
      @(posedge clock);
      #1 map_select_wr = 1'b0;
      repeat (2) @(posedge clock);
      #1 chk("map write", {20'h0, exp}, {20'h0, map_select_bit});
      $display("map write case done");
   endtask : t_map
   task t_irq;
      for (int i = 0; i < 10; i++) begin
         @(posedge clock);
         #1 irq_req = IRQ_RQ[i];
         mask_level = IRQ_MK[i];
         #10 chk("pending", {20'h0, IRQ_VEC[i] != 5'h00}, {20'h0, irq_pending});
         if (IRQ_VEC[i] != 5'h00) begin
            chk("vector", {16'h0, IRQ_VEC[i]}, {16'h0, irq_vector});
            chk("vector addr", vector_base + {IRQ_VEC[i], 1'b0}, irq_addr);
         end
      end
      irq_req = 22'h000000;
      $display("arbitration case done");
   endtask : t_irq
   initial begin
      t_boot(1'b0, 1'b0, 1'b0, BMVP_INT_BOOT, 1'b0);
      t_fetch(21'h020000, 1'b0, BMVP_SRC_BOOT, 1'b0);
      t_fetch(21'h000100, 1'b0, BMVP_SRC_FLASH, 1'b0);
      t_fetch(21'h010000, 1'b0, BMVP_SRC_EXT, 1'b1);
      t_irq();
      t_map(1'b1);
      t_fetch(21'h000010, 1'b0, BMVP_SRC_EXT, 1'b0);
      t_boot(1'b1, 1'b0, 1'b1, BMVP_INT_BOOT, 1'b0);
      t_map(1'b0);
      t_boot(1'b1, 1'b1, 1'b0, BMVP_EXT20_BOOT, 1'b1);
      t_fetch(21'h020000, 1'b0, BMVP_SRC_EXT, 1'b0);
      t_boot(1'b1, 1'b0, 1'b0, BMVP_EXT16_BOOT, 1'b1);
      t_fetch(21'h010004, 1'b0, BMVP_SRC_FLASH, 1'b0);
      chk("flash offset", 21'h000004, fetch_local);
      t_fetch(21'h000010, 1'b0, BMVP_SRC_EXT, 1'b0);
      t_fetch(21'h020000, 1'b0, BMVP_SRC_BOOT, 1'b0);
      t_fetch(21'h100000, 1'b0, BMVP_SRC_EXT, 1'b1);
      t_fetch(21'h100000, 1'b1, BMVP_SRC_EXT, 1'b0);
      close_out();
   end
endmodule : bmvp_top_test
`default_nettype wire
